// ---- verilog/gstmr_pkg.sv ----
// Package for the gated sixteen bit timer: register map, fields, reset values
package gstmr_pkg;

  // Register byte addresses on the AHB-Lite slave
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_COUNT_LO  = 8'h04;
  localparam logic [7:0] OFS_COUNT_HI  = 8'h08;
  localparam logic [7:0] OFS_GATE_SEL  = 8'h0C;
  localparam logic [7:0] OFS_FLAGS     = 8'h10;
  localparam logic [7:0] OFS_IRQ_CTRL  = 8'h14;
  localparam logic [7:0] OFS_OSC_PINS  = 8'h18;

  // Control register fields
  localparam int CTL_TIMER_ON   = 0;
  localparam int CTL_CLK_SRC    = 1;
  localparam int CTL_SYNC_DIS   = 2;
  localparam int CTL_LP_OSC_EN  = 3;
  localparam int CTL_PRESC_LO   = 4;
  localparam int CTL_GATE_EN    = 6;
  localparam int CTL_GATE_INV   = 7;

  // Gate select register fields
  localparam int GSEL_CMP_SYNC  = 0;
  localparam int GSEL_GATE_SRC  = 1;

  // Interrupt control fields (enables register)
  localparam int IRQ_TIMER_EN   = 0;
  localparam int IRQ_PERIPH_EN  = 1;
  localparam int IRQ_GLOBAL_EN  = 2;

  // Reset values
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [7:0] RST_GATE_SEL = 8'h02;
  localparam logic [7:0] GSEL_MASK    = 8'h03;

  // Interrupt vector address reported while the interrupt request is raised
  localparam logic [15:0] IRQ_VECTOR  = 16'h0004;

  // Instruction clock is system clock divided by this
  localparam int INSTR_DIV            = 4;

  // AHB transfer types
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  // External input conditioning state
  typedef enum logic [1:0] {
    GSTMR_ARM_WAIT_LOW = 2'b00,
    GSTMR_ARM_READY    = 2'b01
  } gstmr_arm_e;

  // Joined status for the sleep / interrupt side
  typedef struct packed {
    logic irq_request;
    logic wake_request;
  } gstmr_irq_s;

endpackage : gstmr_pkg

// ---- verilog/gstmr_top.sv ----
// Gated sixteen bit timer with prescaler, gate and AHB-Lite register slave
//
// Function
// - Sixteen bit up-counter in two byte registers; byte writes replace live count.
// - Clock select bit picks instruction clock or external input rising edge.
// - External mode counts rising edges, synchronised or not per sync control.
// - After enable, count write, or high-then-low re-enable, wait for falling edge.
// - Two-bit prescaler divides by 1, 2, 4 or 8.
// - Prescaler is hidden from software; any count byte write clears it.
// - Low-power oscillator used only with internal oscillator, otherwise ignored.
// - Oscillator enabled forces pin directions to input, data reads zero.
// - Sync disable bit in external mode keeps counting through sleep.
// - Count byte reads in asynchronous mode always return a valid value.
// - Mode switches may lose or add a single increment.
// - Gate source is gate pin or second comparator output, reset to comparator.
// - Gate enable lets gate control counting; ignored while timer off.
// - Gate invert set means active-high gate, cleared means active-low.
// - Rollover to zero sets sticky overflow flag; interrupt needs three enables.
// - In sleep only asynchronous counting runs; overflow wakes, vector 0004h.
// - Counter increment clock is provided to the comparator for synchronisation.
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module gstmr_top
  import gstmr_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        external_count_input,
  input  wire logic        lp_osc_clock,
  input  wire logic        internal_oscillator,
  input  wire logic        sleep_mode,
  input  wire logic        gate_pin,
  input  wire logic        second_comparator_output,
  output logic             comparator_sync_enable,
  output logic             increment_clock,
  output logic             osc_pins_forced_input,
  output gstmr_irq_s       irq_out,
  output logic      [15:0] wake_vector
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and nets
  logic [7:0]  timer_control;
  logic [7:0]  comparator_gate_select;
  logic [15:0] count;
  logic        overflow_flag;
  logic [2:0]  irq_enables;
  logic [2:0]  presc_cnt;
  logic [1:0]  instr_div;
  gstmr_arm_e  arm_state;
  logic        ext_sync1;
  logic        ext_sync2;
  logic        ext_prev;
  logic        ext_prev_raw;
  logic        off_high;
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  wr_addr;
  logic        instr_tick;
  logic        ext_level;
  logic        ext_rise;
  logic        ext_fall;
  logic        src_tick;
  logic        presc_tick;
  logic        gate_raw;
  logic        gate_active;
  logic        count_en;
  logic        lp_active;
  logic        count_write;
  logic        addr_ok;
  logic [2:0]  presc_limit;
  logic        rd_sample;
  logic        irq_req;
  logic        wake_req;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ);

  // Capture address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite;
      rd_pend <= addr_ok && !hwrite;
      wr_addr <= addr_ok ? haddr[7:0] : wr_addr;
    end
  end

  assign count_write = wr_pend && ((wr_addr == OFS_COUNT_LO) || (wr_addr == OFS_COUNT_HI));

  // Read data, count sampled in system clock domain so it is always valid
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ok && !hwrite)
    begin
      case (haddr[7:0])
        OFS_CONTROL:  hrdata <= {24'h000000, timer_control};
        OFS_COUNT_LO: hrdata <= {24'h000000, count[7:0]};
        OFS_COUNT_HI: hrdata <= {24'h000000, count[15:8]};
        OFS_GATE_SEL: hrdata <= {24'h000000, comparator_gate_select};
        OFS_FLAGS:    hrdata <= {31'h00000000, overflow_flag};
        OFS_IRQ_CTRL: hrdata <= {29'h00000000, irq_enables};
        OFS_OSC_PINS: hrdata <= {30'h00000000, {2{lp_active}}}; // Direction bits read 1 while forced to input
        default:      hrdata <= 32'h0000_0000;
      endcase
    end
  end
  assign rd_sample = rd_pend;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers, loaded with their reset values at power-on reset (gate select 02h)
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_control          <= RST_CONTROL;
      comparator_gate_select <= RST_GATE_SEL;
      irq_enables            <= 3'h0;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        OFS_CONTROL:  timer_control <= hwdata[7:0];
        OFS_GATE_SEL: comparator_gate_select <= hwdata[7:0] & GSEL_MASK;
        OFS_IRQ_CTRL: irq_enables <= hwdata[2:0];
        default:      irq_enables <= irq_enables;
      endcase
    end
  end

  assign comparator_sync_enable = comparator_gate_select[GSEL_CMP_SYNC];

  ////////////////////////////////////////////////////////////////////////////
  // Clock sources
  // Instruction clock tick, one in four system clocks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      instr_div <= 2'h0;
    else
      instr_div <= instr_div + 2'h1;
  end
  assign instr_tick = (instr_div == 2'(INSTR_DIV - 1));

  // LP oscillator usable only with internal oscillator
  assign lp_active = timer_control[CTL_LP_OSC_EN] && internal_oscillator;
  assign osc_pins_forced_input = lp_active;

  // Two-flop synchroniser of external source; raw path when sync disabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_sync1    <= 1'b0;
      ext_sync2    <= 1'b0;
      ext_prev     <= 1'b0;
      ext_prev_raw <= 1'b0;
    end
    else
    begin
      ext_sync1    <= lp_active ? lp_osc_clock : external_count_input;
      ext_sync2    <= ext_sync1;
      ext_prev     <= ext_sync2;
      ext_prev_raw <= lp_active ? lp_osc_clock : external_count_input;
    end
  end

  // Switching sync mode may drop or add one edge
  assign ext_level = timer_control[CTL_SYNC_DIS] ? (lp_active ? lp_osc_clock : external_count_input)
                                                 : ext_sync2;
  assign ext_rise  = timer_control[CTL_SYNC_DIS] ? (ext_level && !ext_prev_raw)
                                                 : (ext_sync2 && !ext_prev);
  assign ext_fall  = timer_control[CTL_SYNC_DIS] ? (!ext_level && ext_prev_raw)
                                                 : (!ext_sync2 && ext_prev);

  ////////////////////////////////////////////////////////////////////////////
  // Falling-edge arming before first counted rising edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      arm_state <= GSTMR_ARM_WAIT_LOW;
      off_high  <= 1'b0;
    end
    else
    begin
      if (!timer_control[CTL_TIMER_ON])
        off_high <= ext_level;
      if (count_write)
        arm_state <= GSTMR_ARM_WAIT_LOW;
      else if (!timer_control[CTL_TIMER_ON])
        arm_state <= off_high && !ext_level ? GSTMR_ARM_WAIT_LOW : arm_state;
      else if (ext_fall)
        arm_state <= GSTMR_ARM_READY;
    end
  end

  // Source tick selected by clock source bit; sleep stops synchronous sources
  assign src_tick = timer_control[CTL_CLK_SRC]
                    ? (ext_rise && (arm_state == GSTMR_ARM_READY)
                       && (timer_control[CTL_SYNC_DIS] || !sleep_mode))
                    : (instr_tick && !sleep_mode);

  ////////////////////////////////////////////////////////////////////////////
  // Gate: source select, polarity, enable
  assign gate_raw    = comparator_gate_select[GSEL_GATE_SRC] ? second_comparator_output
                                                            : gate_pin;
  assign gate_active = timer_control[CTL_GATE_INV] ? gate_raw : !gate_raw;
  assign count_en    = timer_control[CTL_TIMER_ON]
                       && (!timer_control[CTL_GATE_EN] || gate_active);

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler, hidden, cleared by count writes
  always_comb
  begin
    case (timer_control[CTL_PRESC_LO +: 2])
      2'b00:   presc_limit = 3'h0;
      2'b01:   presc_limit = 3'h1;
      2'b10:   presc_limit = 3'h3;
      default: presc_limit = 3'h7;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      presc_cnt <= 3'h0;
    else if (count_write)
      presc_cnt <= 3'h0;
    else if (src_tick && count_en)
      presc_cnt <= (presc_cnt >= presc_limit) ? 3'h0 : presc_cnt + 3'h1;
  end

  assign presc_tick      = src_tick && count_en && (presc_cnt >= presc_limit);
  assign increment_clock = presc_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Counter: no reset, byte writes replace live count
  always_ff @(posedge hclk)
  begin
    if (wr_pend && (wr_addr == OFS_COUNT_LO))
      count[7:0] <= hwdata[7:0];
    else if (wr_pend && (wr_addr == OFS_COUNT_HI))
      count[15:8] <= hwdata[7:0];
    else if (presc_tick)
      count <= count + 16'h0001;
  end

  // Overflow flag: set wins over software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      overflow_flag <= 1'b0;
    else if (presc_tick && (count == 16'hFFFF) && !count_write)
      overflow_flag <= 1'b1;
    else if (wr_pend && (wr_addr == OFS_FLAGS) && !hwdata[0])
      overflow_flag <= 1'b0;
  end

  // Interrupt and wake requests
  // Interrupt needs the three enables only; wake needs the timer running and the timer and peripheral enables
  assign wake_req    = overflow_flag && timer_control[CTL_TIMER_ON]
                       && irq_enables[IRQ_TIMER_EN] && irq_enables[IRQ_PERIPH_EN];
  assign irq_req     = overflow_flag && irq_enables[IRQ_TIMER_EN]
                       && irq_enables[IRQ_PERIPH_EN] && irq_enables[IRQ_GLOBAL_EN];
  assign irq_out     = '{irq_request: irq_req, wake_request: wake_req};
  assign wake_vector = irq_req ? IRQ_VECTOR : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  prescale_clear_a : assert property (@(posedge hclk) disable iff (!hresetn)
    count_write |=> (presc_cnt == 3'h0))
    else $error("prescaler not cleared by count write");

  overflow_set_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (presc_tick && count == 16'hFFFF && !count_write) |=> overflow_flag && count == 16'h0000)
    else $error("rollover did not set flag");

  stopped_hold_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (!timer_control[CTL_TIMER_ON] && !wr_pend) |=> $stable(count))
    else $error("stopped counter moved");

  gate_block_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (timer_control[CTL_TIMER_ON] && timer_control[CTL_GATE_EN] && !gate_active) |-> !presc_tick)
    else $error("counted with gate inactive");

  arm_wait_a : assert property (@(posedge hclk) disable iff (!hresetn)
    count_write ##1 (arm_state == GSTMR_ARM_WAIT_LOW) |-> !presc_tick || !timer_control[CTL_CLK_SRC])
    else $error("counted before falling edge");

  lp_ignore_a : assert property (@(posedge hclk) disable iff (!hresetn)
    !internal_oscillator |-> !osc_pins_forced_input)
    else $error("lp oscillator active without internal oscillator");

  irq_gate_a : assert property (@(posedge hclk) disable iff (!hresetn)
    irq_out.irq_request |-> overflow_flag && irq_enables == 3'h7)
    else $error("interrupt without all enables");

  sleep_sync_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (sleep_mode && !(timer_control[CTL_CLK_SRC] && timer_control[CTL_SYNC_DIS])) |-> !presc_tick)
    else $error("synchronous count during sleep");

  prescale_div_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (presc_tick && timer_control[CTL_PRESC_LO +: 2] == 2'b11 && !count_write) |=> !presc_tick)
    else $error("divide by eight ticked twice in a row");

  instr_rate_a : assert property (@(posedge hclk) disable iff (!hresetn)
    instr_tick |=> !instr_tick ##1 !instr_tick ##1 !instr_tick ##1 instr_tick)
    else $error("instruction clock not one in four");

  ctl_write_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && wr_addr == OFS_CONTROL) |=> (timer_control == $past(hwdata[7:0])))
    else $error("control write did not land");

  low_write_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && wr_addr == OFS_COUNT_LO) |=> (count[7:0] == $past(hwdata[7:0])))
    else $error("low count byte write did not land");

  high_write_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && wr_addr == OFS_COUNT_HI) |=> (count[15:8] == $past(hwdata[7:0])))
    else $error("high count byte write did not land");

  lp_force_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (timer_control[CTL_LP_OSC_EN] && internal_oscillator) |-> osc_pins_forced_input)
    else $error("oscillator pins not forced to input");

  gate_polarity_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (timer_control[CTL_TIMER_ON] && timer_control[CTL_GATE_EN]
     && (timer_control[CTL_GATE_INV] != gate_raw)) |-> !presc_tick)
    else $error("counted against gate polarity");

  gate_source_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (timer_control[CTL_TIMER_ON] && timer_control[CTL_GATE_EN] && comparator_gate_select[GSEL_GATE_SRC]
     && (timer_control[CTL_GATE_INV] != second_comparator_output)) |-> !presc_tick)
    else $error("comparator gate ignored");

  inc_clock_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (increment_clock && !count_write) |=> (count == $past(count) + 16'h0001))
    else $error("increment clock without count step");

  async_sleep_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (count_en && timer_control[CTL_CLK_SRC] && timer_control[CTL_SYNC_DIS] && ext_rise
     && (arm_state == GSTMR_ARM_READY) && (presc_limit == 3'h0)) |-> presc_tick)
    else $error("unsynchronised edge not counted");

  flag_sticky_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (overflow_flag && !(wr_pend && wr_addr == OFS_FLAGS)) |=> overflow_flag)
    else $error("overflow flag dropped without software clear");

  wake_req_a : assert property (@(posedge hclk) disable iff (!hresetn)
    wake_req |-> (timer_control[CTL_TIMER_ON] && overflow_flag))
    else $error("wake request with timer off");

  read_hold_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_sample && !(addr_ok && !hwrite)) |=> $stable(hrdata))
    else $error("read data moved without a new read");

endmodule // gstmr_top

`default_nettype wire

// ---- tb/gstmr_ext_model.sv ----
// External count pin model: bursts of rising edges on request
`timescale 1ns/100ps
`default_nettype none

module gstmr_ext_model (
  input  wire logic       hclk,
  input  wire logic       go,
  input  wire logic [3:0] n,
  output logic            pin,
  output logic            busy
);
  logic [3:0] left;
  logic [2:0] ph;

  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
  end

  // Square wave of n rising edges, eight cycles per half, rests low between bursts
  always @(posedge hclk)
  begin
    if (go && !busy)
    begin
      busy <= 1'b1;
      left <= n;
      ph <= 3'h0;
    end
    else if (busy)
    begin
      ph <= ph + 3'h1;
      if (ph == 3'h7)
      begin
        pin <= ~pin;
        if (pin)
        begin
          left <= left - 4'h1;
          busy <= (left != 4'h1);
        end
      end
    end
  end
endmodule // gstmr_ext_model
`default_nettype wire

// ---- tb/gstmr_top_tb.sv ----
// Self-checking bench for the gated sixteen bit timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module gstmr_top_tb;
  import gstmr_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, ext_go, osc_int, slp, gpin, cmp, lpclk;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  ext_n;
  logic [15:0] c0, c1, v, wvec;
  wire  logic  hready;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, csync, inc_clk, forced, ext_pin, ext_busy;
  gstmr_irq_s  irq;
  int          errors, cmp_count, inc_n;
  logic [7:0]  gctl [0:6] = '{8'hC1, 8'hC1, 8'h41, 8'h41, 8'hC1, 8'hC1, 8'h81};
  logic [6:0]  glev = 7'b0101001;

  assign hready = hreadyout;

  gstmr_top gstmr_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_count_input(ext_pin), .lp_osc_clock(lpclk),
    .internal_oscillator(osc_int), .sleep_mode(slp), .gate_pin(gpin), .second_comparator_output(cmp),
    .comparator_sync_enable(csync), .increment_clock(inc_clk), .osc_pins_forced_input(forced),
    .irq_out(irq), .wake_vector(wvec));

  gstmr_ext_model gstmr_ext_model_i (.hclk(hclk), .go(ext_go), .n(ext_n), .pin(ext_pin), .busy(ext_busy));

  // Clocks
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial forever begin repeat (4) @(posedge hclk); lpclk <= ~lpclk; end

  // Increment pulses seen on the comparator side
  always @(posedge hclk)
    if (inc_clk === 1'b1) inc_n <= inc_n + 1;

  function automatic logic exp_run(input logic [7:0] ctl, input logic lev);
    return !ctl[6] || (ctl[7] ? lev : !lev);
  endfunction

  task automatic results();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One AHB-Lite single word transfer
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int k;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsel <= 1'b1;
    k = 0;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 100);
    r = hrdata;
    if (k >= 100) begin errors++; results(); end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] r);
    bus(a, 1'b0, 32'h0, r);
  endtask

  task automatic getcnt(output logic [15:0] c);
    logic [31:0] lo, hi;
    rdr(OFS_COUNT_LO, lo);
    rdr(OFS_COUNT_HI, hi);
    c = {hi[7:0], lo[7:0]};
  endtask

  task automatic setcnt(input logic [15:0] c);
    wr(OFS_COUNT_LO, {24'h0, c[7:0]});
    wr(OFS_COUNT_HI, {24'h0, c[15:8]});
  endtask

  // Counter is stopped before the count is written, run, then stopped again
  task automatic run_int(input logic [7:0] ctl, input int cyc, output logic [15:0] c);
    wr(OFS_CONTROL, 32'h0);
    setcnt(16'h0);
    inc_n = 0;
    wr(OFS_CONTROL, {24'h0, ctl});
    repeat (cyc) @(posedge hclk);
    wr(OFS_CONTROL, {24'h0, ctl & 8'hFE});
    getcnt(c);
  endtask

  task automatic pulses(input logic [3:0] n);
    int k;
    ext_n <= n;
    ext_go <= 1'b1;
    @(posedge hclk);
    ext_go <= 1'b0;
    k = 0;
    do begin @(posedge hclk); k++; end while (ext_busy !== 1'b0 && k < 400);
    if (k >= 400) begin errors++; results(); end
    repeat (8) @(posedge hclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, ext_go, osc_int, slp, gpin, cmp, lpclk} = '0;
    {haddr, hwdata, htrans, ext_n} = '0;
    hsize = 3'b010;
    errors = 0;
    cmp_count = 0;
    inc_n = 0;
    void'($urandom(97));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdr(OFS_CONTROL, rd); `CHK("control", 32'h0, rd)
    rdr(OFS_GATE_SEL, rd); `CHK("gate_sel", 32'h2, rd)
    rdr(8'h40, rd); `CHK("unmapped", 32'h0, rd)
    `CHK("hresp", 1'b0, hresp)
    repeat (4)
    begin
      v = 16'($urandom);
      setcnt(v);
      getcnt(c0); `CHK("count", v, c0)
    end
    for (int p = 0; p < 4; p++)
    begin
      run_int({2'b00, 2'(p), 4'h1}, 64 << p, c0);
      `CHK("prescale", 1'b1, (c0 >= 16'd15 && c0 <= 16'd17))
      `CHK("inc_clock", c0, inc_n[15:0])
      repeat (50) @(posedge hclk);
      getcnt(c1); `CHK("hold", c0, c1)
    end
    wr(OFS_IRQ_CTRL, 32'h0);
    setcnt(16'hFFFF);
    wr(OFS_CONTROL, 32'h01);
    repeat (20) @(posedge hclk);
    wr(OFS_CONTROL, 32'h00);
    rdr(OFS_FLAGS, rd); `CHK("ovf_flag", 1'b1, rd[0])
    `CHK("irq_masked", 1'b0, irq.irq_request)
    wr(OFS_IRQ_CTRL, 32'h7);
    #1 `CHK("irq", 1'b1, irq.irq_request)
    `CHK("vector", IRQ_VECTOR, wvec)
    `CHK("wake_off", 1'b0, irq.wake_request)
    @(posedge hclk);
    wr(OFS_CONTROL, 32'h03);
    #1 `CHK("wake_on", 1'b1, irq.wake_request)
    @(posedge hclk);
    wr(OFS_CONTROL, 32'h00);
    wr(OFS_FLAGS, 32'h0);
    rdr(OFS_FLAGS, rd); `CHK("flag_clr", 1'b0, rd[0])
    wr(OFS_IRQ_CTRL, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      gpin <= (i == 4 || i == 5) ? !glev[i] : glev[i];
      cmp <= (i == 4 || i == 5) ? glev[i] : !glev[i];
      wr(OFS_GATE_SEL, (i == 5) ? 32'h3 : (i == 4) ? 32'h2 : 32'h0);
      run_int(gctl[i], 64, c0);
      `CHK("gate", exp_run(gctl[i], glev[i]), (c0 != 16'h0))
      `CHK("cmp_sync", (i == 5), csync)
    end
    slp <= 1'b1;
    run_int(8'h01, 64, c0); `CHK("sleep_int", 16'h0, c0)
    slp <= 1'b0;
    setcnt(16'h0);
    wr(OFS_CONTROL, 32'h03);
    pulses(4'd5);
    getcnt(c0); `CHK("ext_first", 16'd4, c0)
    pulses(4'd5);
    getcnt(c0); `CHK("ext_sync", 16'd9, c0)
    wr(OFS_CONTROL, 32'h07);
    slp <= 1'b1;
    pulses(4'd5);
    slp <= 1'b0;
    getcnt(c0); `CHK("ext_async", 16'd14, c0)
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdr(OFS_CONTROL, rd); `CHK("ctl_rst", 32'h0, rd)
    getcnt(c0); `CHK("cnt_kept", 16'd14, c0)
    osc_int <= 1'b1;
    wr(OFS_CONTROL, 32'h08);
    #1 `CHK("forced", 1'b1, forced)
    // Oscillator start-up wait before the pin register is read
    repeat (20) @(posedge hclk);
    rdr(OFS_OSC_PINS, rd); `CHK("osc_pins", 2'b11, rd[1:0])
    osc_int <= 1'b0;
    @(posedge hclk);
    #1 `CHK("lp_ignored", 1'b0, forced)
    results();
  end
endmodule // gstmr_top_tb
`default_nettype wire
